// ---- osg_consts.vh ----
// register map, reset values and timing counts of the sync timing generator
`ifndef OSG_CONSTS_VH
`define OSG_CONSTS_VH
`define OSG_SUB_SYNC_CTRL 8'h20
`define OSG_SUB_LINE_LEN 8'h21
`define OSG_SUB_NEWLINE 8'h22
`define OSG_SUB_PAD_STR 8'h23
`define OSG_SUB_SER_CTRL 8'h24
`define OSG_SUB_HC_START 8'h26
`define OSG_SUB_HC_STOP 8'h27
`define OSG_SUB_AV_START 8'h28
`define OSG_SUB_AV_STOP 8'h29
`define OSG_SUB_FS_DELAY 8'h30
`define OSG_RST_SYNC_CTRL 8'h00
`define OSG_RST_LINE_LEN 16'h050F
`define OSG_RST_NEWLINE 16'h0090
`define OSG_RST_PAD_STR 16'h0000
`define OSG_RST_SER_CTRL 8'h20
`define OSG_RST_HC_START 16'h0032
`define OSG_RST_HC_STOP 16'h0320
`define OSG_RST_AV_START 16'h0090
`define OSG_RST_AV_STOP 16'h0500
`define OSG_RST_FS_DELAY 8'h00
`define OSG_RST_STRENGTH 4'h0
`define OSG_PAD_GRP_MEM 6'h20
`define OSG_PAD_GRP_SYNC 6'h21
`define OSG_PAD_WR_BIT 10
`define OSG_SC_HS_INV 2
`define OSG_SC_HC_INV 3
`define OSG_SC_VS_INV 4
`define OSG_OC_BLANK_DIS 0
`define OSG_OC_VSRC 1
`define OSG_OC_HDR_SUP 2
`define OSG_OC_FMT656 3
`define OSG_OC_REFCLK 4
`define OSG_OC_OUTPUT_FORMAT_SELECT 5
`define OSG_AV_GATE 12
`define OSG_AV_STD 13
`define OSG_AV_NOINTL 14
`define OSG_AV_FREERUN 15
`define OSG_TP_ENABLE 11
`define OSG_TP_CHROMA_FMT 14
`define OSG_TP_ZERO_C 15
`define OSG_HS_WIDTH 11'h040
`define OSG_VBI_LINES 10'h016
`define OSG_FIELD_625 10'h138
`define OSG_FIELD_525 10'h106
`define OSG_FS_STEP 3
`define OSG_Y_LOW 8'h10
`define OSG_Y_MID 8'h5A
`define OSG_Y_HIGH 8'hF0
`define OSG_C_ZERO 8'h80
`endif

// ---- osg_sync_timing.v ----
// output sync timing generator with its serial register port
`timescale 1ns/1ps
`include "osg_consts.vh"
module osg_sync_timing #(
  parameter [6:0] DEV_ADDR = 7'h2B // arbitrary bus address
) (
  input wire CLOCK, // 25 MHz system clock
  input wire RESET, // synchronous, active high
  input wire SCL, // serial bus clock pin
  input wire SDA_IN, // serial bus data level
  output reg SDA_OUT, // data drive level, always low
  output reg SDA_OE, // high while pulling data low
  input wire LINE_LOCKED_CLOCK, // pixel clock from the decoder
  input wire FIELD_SYNC_IN, // vertical sync from the input
  input wire SCALER_BYPASS, // one-line bypass of the scaler
  input wire [7:0] Y_IN, // luma from the video path
  input wire [7:0] C_IN, // chroma from the video path
  output reg LINE_SYNC_PULSE, // line sync
  output reg HORIZONTAL_CLAMP_PULSE, // clamp pulse
  output reg FIELD_SYNC_PULSE, // delayed field sync
  output reg ACTIVE_VIDEO_WINDOW, // active video
  output reg VERTICAL_VALID_FLAG, // vertical flag
  output reg HEADER_ENABLE, // timing headers allowed
  output reg NEXT_LINE_READOUT, // one tick at newline value
  output reg [7:0] Y_OUT, // luma out
  output reg [7:0] C_OUT, // chroma out
  output reg SERIAL_VIDEO_FORMAT, // serial video format on
  output reg REFERENCE_CLOCK_SELECT, // 1 selects double rate
  output reg OUTPUT_FORMAT_SELECT, // 1 selects line-locked mode
  output reg [3:0] PAD_STRENGTH_MEM, // memory control pad drive
  output reg [3:0] PAD_STRENGTH_SYNC // sync pad drive
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_RX = 5'h02;
localparam [4:0] ST_ACK = 5'h04;
localparam [4:0] ST_TX = 5'h08;
localparam [4:0] ST_MACK = 5'h10;

function is_wide;
  input [7:0] sub;
  begin
    is_wide = (sub != `OSG_SUB_SYNC_CTRL) && (sub != `OSG_SUB_SER_CTRL) &&
              (sub != `OSG_SUB_FS_DELAY);
  end
endfunction

// start wins over stop when both match on one count
function win_next;
  input cur;
  input [10:0] cnt;
  input [10:0] start;
  input [10:0] stop;
  begin
    if (cnt == start)
      win_next = 1'b1;
    else if (cnt == stop)
      win_next = 1'b0;
    else
      win_next = cur;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// serial register port

reg [2:0] scl_s;
reg [2:0] sda_s;
reg [4:0] st_q;
reg [3:0] bitc_q;
reg [7:0] sr_q;
reg [7:0] tx_q;
reg [1:0] nbyte_q;
reg rw_q;
reg [7:0] sub_q;
reg hi_q;
reg [7:0] hold_q;
reg wr_stb_q;
reg [15:0] wr_data_q;
reg [15:0] rd_val;
reg [7:0] rd_byte;

wire scl_rise = scl_s[1] & ~scl_s[2];
wire scl_fall = ~scl_s[1] & scl_s[2];
wire bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
wire bus_stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

always @* begin
  rd_byte = (is_wide(sub_q) && !hi_q) ? rd_val[15:8] : rd_val[7:0];
end

always @(posedge CLOCK) begin
  scl_s <= {scl_s[1:0], SCL};
  sda_s <= {sda_s[1:0], SDA_IN};
  if (RESET) begin
    st_q <= ST_IDLE;
    bitc_q <= 4'h0;
    sr_q <= 8'h00;
    tx_q <= 8'h00;
    nbyte_q <= 2'h0;
    rw_q <= 1'b0;
    sub_q <= 8'h00;
    hi_q <= 1'b0;
    hold_q <= 8'h00;
    wr_stb_q <= 1'b0;
    wr_data_q <= 16'h0000;
    SDA_OUT <= 1'b0;
    SDA_OE <= 1'b0;
  end else begin
    wr_stb_q <= 1'b0;
    if (bus_start) begin
      st_q <= ST_RX;
      bitc_q <= 4'h0;
      nbyte_q <= 2'h0;
      SDA_OE <= 1'b0;
    end else if (bus_stop) begin
      st_q <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            sr_q <= {sr_q[6:0], sda_s[1]};
            bitc_q <= bitc_q + 4'h1;
          end else if (scl_fall && bitc_q == 4'h8) begin
            SDA_OE <= 1'b1;
            st_q <= ST_ACK;
            if (nbyte_q != 2'h2)
              nbyte_q <= nbyte_q + 2'h1;
            case (nbyte_q)
              2'h0: begin
                rw_q <= sr_q[0];
                hi_q <= 1'b0;
                if (sr_q[7:1] != DEV_ADDR) begin
                  SDA_OE <= 1'b0;
                  st_q <= ST_IDLE;
                end
              end
              2'h1: begin
                sub_q <= sr_q;
                hi_q <= 1'b0;
              end
              default: begin
                // wide registers take high byte first, commit on low
                if (is_wide(sub_q) && !hi_q) begin
                  hold_q <= sr_q;
                  hi_q <= 1'b1;
                end else begin
                  wr_stb_q <= 1'b1;
                  wr_data_q <= is_wide(sub_q) ? {hold_q, sr_q}
                                              : {8'h00, sr_q};
                  hi_q <= 1'b0;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              SDA_OE <= ~rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
              hi_q <= is_wide(sub_q) & ~hi_q;
              bitc_q <= 4'h1;
              st_q <= ST_TX;
            end else begin
              SDA_OE <= 1'b0;
              bitc_q <= 4'h0;
              st_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitc_q == 4'h8) begin
              SDA_OE <= 1'b0;
              st_q <= ST_MACK;
            end else begin
              SDA_OE <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bitc_q <= bitc_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s[1])
            st_q <= ST_IDLE;
          else if (scl_fall) begin
            SDA_OE <= ~rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            hi_q <= is_wide(sub_q) & ~hi_q;
            bitc_q <= 4'h1;
            st_q <= ST_TX;
          end
        end
        ST_IDLE: begin
          SDA_OE <= 1'b0;
        end
        default: begin
          st_q <= ST_IDLE;
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// register file

reg [7:0] sync_ctrl_q;
reg [15:0] line_len_q;
reg [15:0] newline_q;
reg [15:0] pad_ctl_q;
reg [7:0] ser_ctrl_q;
reg [15:0] hc_start_q;
reg [15:0] hc_stop_q;
reg [15:0] av_start_q;
reg [15:0] av_stop_q;
reg [7:0] fs_delay_q;
reg [3:0] str_sel;

always @* begin
  if (pad_ctl_q[9:4] == `OSG_PAD_GRP_MEM)
    str_sel = PAD_STRENGTH_MEM;
  else if (pad_ctl_q[9:4] == `OSG_PAD_GRP_SYNC)
    str_sel = PAD_STRENGTH_SYNC;
  else
    str_sel = 4'h0;
  case (sub_q)
    `OSG_SUB_SYNC_CTRL: rd_val = {8'h00, sync_ctrl_q};
    `OSG_SUB_LINE_LEN: rd_val = line_len_q;
    `OSG_SUB_NEWLINE: rd_val = newline_q;
    `OSG_SUB_PAD_STR: rd_val = {pad_ctl_q[15:4], str_sel};
    `OSG_SUB_SER_CTRL: rd_val = {8'h00, ser_ctrl_q};
    `OSG_SUB_HC_START: rd_val = hc_start_q;
    `OSG_SUB_HC_STOP: rd_val = hc_stop_q;
    `OSG_SUB_AV_START: rd_val = av_start_q;
    `OSG_SUB_AV_STOP: rd_val = av_stop_q;
    `OSG_SUB_FS_DELAY: rd_val = {8'h00, fs_delay_q};
    default: rd_val = 16'h0000;
  endcase
end

always @(posedge CLOCK) begin
  if (RESET) begin
    sync_ctrl_q <= `OSG_RST_SYNC_CTRL;
    line_len_q <= `OSG_RST_LINE_LEN;
    newline_q <= `OSG_RST_NEWLINE;
    pad_ctl_q <= `OSG_RST_PAD_STR;
    ser_ctrl_q <= `OSG_RST_SER_CTRL;
    hc_start_q <= `OSG_RST_HC_START;
    hc_stop_q <= `OSG_RST_HC_STOP;
    av_start_q <= `OSG_RST_AV_START;
    av_stop_q <= `OSG_RST_AV_STOP;
    fs_delay_q <= `OSG_RST_FS_DELAY;
    PAD_STRENGTH_MEM <= `OSG_RST_STRENGTH;
    PAD_STRENGTH_SYNC <= `OSG_RST_STRENGTH;
  end else if (wr_stb_q) begin
    case (sub_q)
      `OSG_SUB_SYNC_CTRL: sync_ctrl_q <= wr_data_q[7:0];
      `OSG_SUB_LINE_LEN: line_len_q <= wr_data_q;
      `OSG_SUB_NEWLINE: newline_q <= wr_data_q;
      `OSG_SUB_PAD_STR: begin
        pad_ctl_q <= wr_data_q;
        // a write with the write bit clear only selects a group to read
        if (wr_data_q[`OSG_PAD_WR_BIT] &&
            wr_data_q[9:4] == `OSG_PAD_GRP_MEM)
          PAD_STRENGTH_MEM <= wr_data_q[3:0];
        if (wr_data_q[`OSG_PAD_WR_BIT] &&
            wr_data_q[9:4] == `OSG_PAD_GRP_SYNC)
          PAD_STRENGTH_SYNC <= wr_data_q[3:0];
      end
      `OSG_SUB_SER_CTRL: ser_ctrl_q <= wr_data_q[7:0];
      `OSG_SUB_HC_START: hc_start_q <= wr_data_q;
      `OSG_SUB_HC_STOP: hc_stop_q <= wr_data_q;
      `OSG_SUB_AV_START: av_start_q <= wr_data_q;
      `OSG_SUB_AV_STOP: av_stop_q <= wr_data_q;
      `OSG_SUB_FS_DELAY: fs_delay_q <= wr_data_q[7:0];
      default: sync_ctrl_q <= sync_ctrl_q;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// sync counter, vertical timing and field sync delay

reg [2:0] llc_s;
reg [1:0] fsi_s;
reg fsi_d;
reg [10:0] cnt_q;
reg [9:0] line_q;
reg field_q;
reg [10:0] dly_q;
reg pend_q;
reg fs_q;
reg hs_w;
reg hc_w;
reg av_w;

// pixel clock is slow against CLOCK, so edges are found by sampling
wire tick = llc_s[1] & ~llc_s[2];
wire wrap = tick & (cnt_q == line_len_q[10:0]);
wire freerun = av_start_q[`OSG_AV_FREERUN];
wire [9:0] flen = av_start_q[`OSG_AV_STD] ? `OSG_FIELD_525
                                          : `OSG_FIELD_625;
wire extra = field_q & ~av_start_q[`OSG_AV_NOINTL];
wire fr_evt = wrap & (line_q == flen - 10'h001 + {9'h000, extra});
wire in_evt = fsi_s[1] & ~fsi_d;
wire vert_evt = freerun ? fr_evt : in_evt;
wire [7:0] dly_val = fs_delay_q;
wire fs_fire = (vert_evt && dly_val == 8'h00) ||
               (pend_q && tick && dly_q == 11'h001);
wire vbi = line_q < `OSG_VBI_LINES;

always @(posedge CLOCK) begin
  llc_s <= {llc_s[1:0], LINE_LOCKED_CLOCK};
  fsi_s <= {fsi_s[0], FIELD_SYNC_IN};
  fsi_d <= fsi_s[1];
  if (RESET) begin
    cnt_q <= 11'h000;
    line_q <= 10'h000;
    field_q <= 1'b0;
    dly_q <= 11'h000;
    pend_q <= 1'b0;
    fs_q <= 1'b0;
    hs_w <= 1'b0;
    hc_w <= 1'b0;
    av_w <= 1'b0;
  end else begin
    if (tick) begin
      cnt_q <= wrap ? 11'h000 : cnt_q + 11'h001;
      hs_w <= win_next(hs_w, cnt_q, 11'h000, `OSG_HS_WIDTH);
      hc_w <= win_next(hc_w, cnt_q, hc_start_q[10:0],
                       hc_stop_q[10:0]);
      av_w <= win_next(av_w, cnt_q, av_start_q[10:0],
                       av_stop_q[10:0]);
    end
    if (vert_evt) begin
      line_q <= 10'h000;
      field_q <= freerun ? ~field_q : 1'b0;
    end else if (wrap && line_q != 10'h3FF)
      line_q <= line_q + 10'h001;
    if (vert_evt && dly_val != 8'h00) begin
      dly_q <= {dly_val, 3'h0};
      pend_q <= 1'b1;
    end else if (pend_q && tick) begin
      dly_q <= dly_q - 11'h001;
      if (dly_q == 11'h001)
        pend_q <= 1'b0;
    end
    // field sync lasts until the line wrap after it fires
    if (fs_fire)
      fs_q <= 1'b1;
    else if (wrap)
      fs_q <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// data path, test pattern and outputs

reg [7:0] pipe_y [0:2];
reg [7:0] pipe_c [0:2];
reg [7:0] tp_y;
reg [7:0] tp_c;
reg [7:0] ent_y;
reg [7:0] ent_c;
reg [7:0] sel_y;
reg [7:0] sel_c;

wire [15:0] tpc = av_stop_q;
wire fmt656 = ser_ctrl_q[`OSG_OC_FMT656];
wire gate = av_start_q[`OSG_AV_GATE] & vbi;
wire blank = (fmt656 & ~ser_ctrl_q[`OSG_OC_BLANK_DIS] & (~av_w | vbi))
             | gate;
wire cr_phase = tpc[`OSG_TP_CHROMA_FMT] ? cnt_q[1] : cnt_q[0];

always @* begin
  case (tpc[13:12])
    2'h0: tp_y = (cnt_q[7:0] < `OSG_Y_LOW) ? `OSG_Y_LOW :
                 (cnt_q[7:0] > `OSG_Y_HIGH) ? `OSG_Y_HIGH : cnt_q[7:0];
    2'h1: tp_y = `OSG_Y_LOW;
    2'h2: tp_y = `OSG_Y_MID;
    default: tp_y = `OSG_Y_HIGH;
  endcase
  // bars step with the upper counter bits, cb and cr by pixel phase
  if (tpc[13:12] == 2'h0 && !tpc[`OSG_TP_ZERO_C])
    tp_c = cr_phase ? {cnt_q[9:8], 6'h20} : {cnt_q[10:8], 5'h10};
  else
    tp_c = `OSG_C_ZERO;
  if (tpc[`OSG_TP_ENABLE]) begin
    ent_y = tp_y;
    ent_c = tp_c;
  end else if (blank) begin
    ent_y = `OSG_Y_LOW;
    ent_c = `OSG_C_ZERO;
  end else begin
    ent_y = Y_IN;
    ent_c = C_IN;
  end
  case (sync_ctrl_q[1:0])
    2'h0: begin
      sel_y = ent_y;
      sel_c = ent_c;
    end
    2'h1: begin
      sel_y = pipe_y[0];
      sel_c = pipe_c[0];
    end
    2'h2: begin
      sel_y = pipe_y[1];
      sel_c = pipe_c[1];
    end
    default: begin
      sel_y = pipe_y[2];
      sel_c = pipe_c[2];
    end
  endcase
end

always @(posedge CLOCK) begin
  if (RESET) begin
    pipe_y[0] <= `OSG_Y_LOW;
    pipe_y[1] <= `OSG_Y_LOW;
    pipe_y[2] <= `OSG_Y_LOW;
    pipe_c[0] <= `OSG_C_ZERO;
    pipe_c[1] <= `OSG_C_ZERO;
    pipe_c[2] <= `OSG_C_ZERO;
    Y_OUT <= `OSG_Y_LOW;
    C_OUT <= `OSG_C_ZERO;
    LINE_SYNC_PULSE <= 1'b0;
    HORIZONTAL_CLAMP_PULSE <= 1'b0;
    FIELD_SYNC_PULSE <= 1'b0;
    ACTIVE_VIDEO_WINDOW <= 1'b0;
    VERTICAL_VALID_FLAG <= 1'b0;
    HEADER_ENABLE <= 1'b0;
    NEXT_LINE_READOUT <= 1'b0;
    SERIAL_VIDEO_FORMAT <= 1'b0;
    REFERENCE_CLOCK_SELECT <= 1'b0;
    OUTPUT_FORMAT_SELECT <= 1'b1;
  end else begin
    if (tick) begin
      pipe_y[0] <= ent_y;
      pipe_y[1] <= pipe_y[0];
      pipe_y[2] <= pipe_y[1];
      pipe_c[0] <= ent_c;
      pipe_c[1] <= pipe_c[0];
      pipe_c[2] <= pipe_c[1];
      Y_OUT <= sel_y;
      C_OUT <= sel_c;
    end
    // a newline below 32 is not guarded; software must avoid it
    NEXT_LINE_READOUT <= tick & ~SCALER_BYPASS &
                         (cnt_q == newline_q[10:0]);
    LINE_SYNC_PULSE <= hs_w ^ sync_ctrl_q[`OSG_SC_HS_INV];
    HORIZONTAL_CLAMP_PULSE <= hc_w ^ sync_ctrl_q[`OSG_SC_HC_INV];
    FIELD_SYNC_PULSE <= fs_q ^ sync_ctrl_q[`OSG_SC_VS_INV];
    ACTIVE_VIDEO_WINDOW <= av_w & ~gate;
    VERTICAL_VALID_FLAG <= ser_ctrl_q[`OSG_OC_VSRC] ? fs_q : ~vbi;
    HEADER_ENABLE <= fmt656 &
                     ~(ser_ctrl_q[`OSG_OC_HDR_SUP] & vbi);
    SERIAL_VIDEO_FORMAT <= fmt656;
    REFERENCE_CLOCK_SELECT <= ser_ctrl_q[`OSG_OC_REFCLK];
    OUTPUT_FORMAT_SELECT <= ser_ctrl_q[`OSG_OC_OUTPUT_FORMAT_SELECT];
  end
end

endmodule

// ---- osg_sync_timing_asserts.sv ----
// port checker of the sync timing generator
`timescale 1ns/1ps
module osg_sync_timing_asserts (
  input wire CLOCK, // system clock
  input wire RESET, // sync reset
  input wire SCL, // bus clock pin
  input wire SDA_OUT, // data drive level
  input wire SDA_OE, // data drive enable
  input wire SCALER_BYPASS, // bypass level
  input wire LINE_SYNC_PULSE, // line sync
  input wire NEXT_LINE_READOUT, // readout tick
  input wire HEADER_ENABLE, // headers allowed
  input wire SERIAL_VIDEO_FORMAT, // serial format
  input wire REFERENCE_CLOCK_SELECT, // reference clock
  input wire OUTPUT_FORMAT_SELECT, // output mode
  input wire [7:0] Y_OUT, // luma
  input wire [7:0] C_OUT, // chroma
  input wire [3:0] PAD_STRENGTH_MEM, // memory pads
  input wire [3:0] PAD_STRENGTH_SYNC // sync pads
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  reset_vals_a: assert property ($past(RESET) |->
    OUTPUT_FORMAT_SELECT && Y_OUT == 8'h10 && C_OUT == 8'h80 && !SDA_OE
    && PAD_STRENGTH_MEM == 4'h0 && PAD_STRENGTH_SYNC == 4'h0)
    else $error("outputs not at reset values");
  readout_pulse_a: assert property (
    NEXT_LINE_READOUT |=> !NEXT_LINE_READOUT)
    else $error("readout tick longer than one cycle");
  bypass_quiet_a: assert property (SCALER_BYPASS &&
    $past(SCALER_BYPASS) && $past(SCALER_BYPASS, 2) |-> !NEXT_LINE_READOUT)
    else $error("readout tick during scaler bypass");
  sync_width_a: assert property (
    $rose(LINE_SYNC_PULSE) |=> LINE_SYNC_PULSE [*8])
    else $error("line sync pulse too short");
  drive_low_a: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data pin driven high");
  mode_change_a: assert property (
    $changed(OUTPUT_FORMAT_SELECT) |-> !SCL)
    else $error("output mode changed outside a bus write");
  refclk_change_a: assert property (
    $changed(REFERENCE_CLOCK_SELECT) |-> !SCL)
    else $error("reference clock changed outside a bus write");
  pad_change_a: assert property ($changed(PAD_STRENGTH_SYNC) ||
    $changed(PAD_STRENGTH_MEM) |-> !SCL)
    else $error("pad strength changed outside a bus write");
  header_fmt_a: assert property (HEADER_ENABLE |->
    SERIAL_VIDEO_FORMAT || $past(SERIAL_VIDEO_FORMAT))
    else $error("headers without serial format");
endmodule
bind osg_sync_timing osg_sync_timing_asserts osg_sync_timing_asserts_inst (
  .CLOCK(CLOCK), .RESET(RESET), .SCL(SCL), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .SCALER_BYPASS(SCALER_BYPASS),
  .LINE_SYNC_PULSE(LINE_SYNC_PULSE), .NEXT_LINE_READOUT(NEXT_LINE_READOUT),
  .HEADER_ENABLE(HEADER_ENABLE), .SERIAL_VIDEO_FORMAT(SERIAL_VIDEO_FORMAT),
  .REFERENCE_CLOCK_SELECT(REFERENCE_CLOCK_SELECT),
  .OUTPUT_FORMAT_SELECT(OUTPUT_FORMAT_SELECT), .Y_OUT(Y_OUT), .C_OUT(C_OUT),
  .PAD_STRENGTH_MEM(PAD_STRENGTH_MEM), .PAD_STRENGTH_SYNC(PAD_STRENGTH_SYNC));

// ---- osg_sync_timing_test.sv ----
// self-checking bench of the sync timing generator
`timescale 1ns/1ps
module osg_sync_timing_test;
  localparam [6:0] ADDR = 7'h2B; // arbitrary bus address
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic scl = 1'b1;
  logic sda_q = 1'b1;
  logic line_locked_clock = 1'b0;
  logic fs_in = 1'b0;
  logic bypass = 1'b0;
  logic [7:0] y_in = 8'h77;
  logic [7:0] c_in = 8'h3C;
  wire sda_w, sda_out, sda_oe, hs, hc, fs, av, vertical_valid_flag, hdr, nlr;
  wire svf, refc, ofs;
  wire [7:0] y_out, c_out;
  wire [3:0] pad_m, pad_s;
  wire [15:0] line_px, hc_px, av_px;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_wait, n0, n2;
  logic [15:0] v;
  logic ack;
  logic [7:0] subs [7] = '{8'h21, 8'h26, 8'h27, 8'h24, 8'h30, 8'h23, 8'h25};
  logic [15:0] rstv [7] = '{16'h050F, 16'h0032, 16'h0320, 16'h0020,
    16'h0000, 16'h0000, 16'h0000};
  logic [7:0] wsub [6] = '{8'h21, 8'h26, 8'h27, 8'h28, 8'h29, 8'h22};
  logic [15:0] wval [6] = '{16'h0063, 16'h000A, 16'h001E, 16'h0028,
    16'h005A, 16'h0032};
  logic [7:0] ye [3] = '{8'h10, 8'h5A, 8'hF0};
  assign sda_w = sda_oe ? 1'b0 : sda_q; // open drain with pull-up
  initial forever #20 clock = ~clock;
  initial begin
    #7;
    forever #160 line_locked_clock = ~line_locked_clock;
  end
  osg_sync_timing #(.DEV_ADDR(ADDR)) osg_sync_timing_inst (
    .CLOCK(clock), .RESET(reset), .SCL(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LINE_LOCKED_CLOCK(line_locked_clock),
    .FIELD_SYNC_IN(fs_in), .SCALER_BYPASS(bypass), .Y_IN(y_in),
    .C_IN(c_in), .LINE_SYNC_PULSE(hs), .HORIZONTAL_CLAMP_PULSE(hc),
    .FIELD_SYNC_PULSE(fs), .ACTIVE_VIDEO_WINDOW(av),
    .VERTICAL_VALID_FLAG(vertical_valid_flag), .HEADER_ENABLE(hdr),
    .NEXT_LINE_READOUT(nlr), .Y_OUT(y_out), .C_OUT(c_out),
    .SERIAL_VIDEO_FORMAT(svf), .REFERENCE_CLOCK_SELECT(refc),
    .OUTPUT_FORMAT_SELECT(ofs), .PAD_STRENGTH_MEM(pad_m),
    .PAD_STRENGTH_SYNC(pad_s));
  osg_video_sink osg_video_sink_inst (.line_locked_clock(line_locked_clock), .hs(hs), .hc(hc), .av(av),
    .line_px(line_px), .hc_px(hc_px), .av_px(av_px));
  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bus phases of ten clocks keep clear of the eight-clock minimum
  task half;
    repeat (10) @(posedge clock);
  endtask
  task bitx(input logic b, output logic r);
    sda_q <= b;
    half;
    scl <= 1'b1;
    half;
    r = sda_w;
    scl <= 1'b0;
    half;
  endtask
  task byte_x(input logic [7:0] d, input logic a, output logic [7:0] r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
      r[i] = b;
    end
    bitx(a, ack);
  endtask
  task start;
    sda_q <= 1'b1;
    half;
    scl <= 1'b1;
    half;
    sda_q <= 1'b0;
    half;
    scl <= 1'b0;
    half;
  endtask
  task stop;
    sda_q <= 1'b0;
    half;
    scl <= 1'b1;
    half;
    sda_q <= 1'b1;
    half;
  endtask
  function logic wide(input logic [7:0] s);
    return s != 8'h20 && s != 8'h24 && s != 8'h30;
  endfunction
  task head(input logic [7:0] s);
    logic [7:0] r;
    start;
    byte_x({ADDR, 1'b0}, 1'b1, r);
    check({15'h0000, ack}, 16'h0000);
    byte_x(s, 1'b1, r);
  endtask
  task wr(input logic [7:0] s, input logic [15:0] d);
    logic [7:0] r;
    head(s);
    if (wide(s))
      byte_x(d[15:8], 1'b1, r);
    byte_x(d[7:0], 1'b1, r);
    stop;
    half;
  endtask
  task rd(input logic [7:0] s, output logic [15:0] d);
    logic [7:0] r;
    head(s);
    start;
    byte_x({ADDR, 1'b1}, 1'b1, r);
    d = 16'h0000;
    if (wide(s)) begin
      byte_x(8'hFF, 1'b0, r);
      d[15:8] = r;
    end
    byte_x(8'hFF, 1'b1, r);
    d[7:0] = r;
    stop;
  endtask
  ////////////////////////////////////////////////////////////////////////
  function logic sel(input int k);
    case (k)
      0: return hs;
      1: return av;
      2: return fs;
      default: return nlr;
    endcase
  endfunction
  task wait_for(input int k, input logic lv);
    n_wait = 0;
    while (sel(k) !== lv && n_wait < 20000) begin
      @(posedge clock);
      n_wait++;
    end
    if (n_wait == 20000) begin
      n_mismatch++;
      $display("mismatch at %0t: wait ran out", $time);
    end
  endtask
  task next_line;
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
  endtask
  // clocks that a signal is high over one line of 100 pixels
  task count_hi(input int k, output int n);
    n = 0;
    next_line;
    repeat (800) begin
      @(posedge clock);
      if (sel(k) === 1'b1)
        n++;
    end
  endtask
  task settle(input int n);
    repeat (n) next_line;
    repeat (16) @(posedge clock);
  endtask
  // five pixels after the window reaches the given level
  task y_at(input logic lv);
    wait_for(1, ~lv);
    wait_for(1, lv);
    repeat (40) @(posedge clock);
  endtask
  task y_check(input logic [7:0] e, input logic [7:0] ec);
    y_at(1'b1);
    check({8'h00, y_out}, {8'h00, e});
    check({8'h00, c_out}, {8'h00, ec});
  endtask
  // event raised at a fixed phase of the pixel clock every time
  task fs_delay(output int n);
    wait_for(2, 1'b0);
    @(posedge line_locked_clock);
    @(posedge clock);
    fs_in <= 1'b1;
    wait_for(2, 1'b1);
    n = n_wait;
    fs_in <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc++;
    if (cyc == 98000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    check({15'h0000, ofs}, 16'h0001);
    foreach (subs[i]) begin
      rd(subs[i], v);
      check(v, rstv[i]);
    end
    foreach (wsub[i])
      wr(wsub[i], wval[i]);
    rd(8'h21, v);
    check(v, 16'h0063);
    settle(3);
    check(line_px, 16'h0064);
    check(hc_px, 16'h0014);
    check(av_px, 16'h0032);
    count_hi(3, n0);
    check(n0[15:0], 16'h0001);
    bypass <= 1'b1;
    count_hi(3, n0);
    check(n0[15:0], 16'h0000);
    bypass <= 1'b0;
    wr(8'h20, 16'h0008);
    settle(2);
    check(hc_px, 16'h0050);
    wr(8'h20, 16'h0000);
    wr(8'h24, 16'h0018);
    check({13'h0000, svf, refc, ofs}, 16'h0006);
    check({15'h0000, hdr}, 16'h0001);
    rd(8'h24, v);
    check(v, 16'h0018);
    wr(8'h24, 16'h0020);
    wr(8'h23, 16'h0615);
    wr(8'h23, 16'h060F);
    wr(8'h23, 16'h0210);
    check({8'h00, pad_m, pad_s}, 16'h00F5);
    rd(8'h23, v);
    check(v, 16'h0215);
    y_check(8'h77, 8'h3C);
    wr(8'h24, 16'h0028);
    y_at(1'b0);
    check({8'h00, y_out}, 16'h0010);
    wr(8'h24, 16'h0029);
    y_at(1'b0);
    check({8'h00, y_out}, 16'h0077);
    wr(8'h24, 16'h0020);
    for (int m = 1; m <= 3; m++) begin
      wr(8'h29, {2'b00, m[1:0], 12'h85A});
      y_check(ye[m - 1], 8'h80);
    end
    // ramp sampled at one window phase with delay 0, then delay 3
    wr(8'h29, 16'h085A);
    y_at(1'b1);
    v = {8'h00, y_out};
    check({15'h0000, c_out != 8'h80}, 16'h0001);
    wr(8'h29, 16'h885A);
    wr(8'h20, 16'h0003);
    y_at(1'b1);
    check({8'h00, c_out}, 16'h0080);
    check({8'h00, v[7:0] - y_out}, 16'h0003);
    wr(8'h20, 16'h0000);
    wr(8'h29, 16'h005A);
    fs_delay(n0);
    wr(8'h30, 16'h0002);
    fs_delay(n2);
    check({15'h0000, n2 - n0 >= 121 && n2 - n0 <= 128}, 16'h0001);
    check({15'h0000, vertical_valid_flag}, 16'h0000);
    wr(8'h24, 16'h002C);
    check({14'h0000, svf, hdr}, 16'h0002);
    wr(8'h24, 16'h0020);
    // still inside the blanking lines that follow the event
    wr(8'h28, 16'h1028);
    count_hi(1, n0);
    check(n0[15:0], 16'h0000);
    wr(8'h28, 16'h0028);
    count_hi(1, n0);
    check(n0[15:0], 16'h0190);
    finish_test;
  end
endmodule

// ---- osg_video_sink.sv ----
// downstream sink measuring line timing in pixel clocks
`timescale 1ns/1ps
module osg_video_sink (
  input wire logic line_locked_clock, // pixel clock
  input wire logic hs, // line sync
  input wire logic hc, // clamp pulse
  input wire logic av, // active video
  output logic [15:0] line_px, // pixels per line
  output logic [15:0] hc_px, // clamp pixels per line
  output logic [15:0] av_px // active pixels per line
);
  logic [15:0] n_line = 16'h0000;
  logic [15:0] n_hc = 16'h0000;
  logic [15:0] n_av = 16'h0000;
  logic hs_q = 1'b0;
  initial begin
    line_px = 16'h0000;
    hc_px = 16'h0000;
    av_px = 16'h0000;
  end
  // outputs settle a few system clocks after the pixel edge, so the
  // pixel edge itself sees the previous, stable pixel
  always @(posedge line_locked_clock) begin
    hs_q <= hs;
    if (hs && !hs_q) begin
      line_px <= n_line;
      hc_px <= n_hc;
      av_px <= n_av;
      n_line <= 16'h0001;
      n_hc <= {15'h0000, hc};
      n_av <= {15'h0000, av};
    end else begin
      n_line <= n_line + 16'h0001;
      n_hc <= n_hc + {15'h0000, hc};
      n_av <= n_av + {15'h0000, av};
    end
  end
endmodule
